// File: hw/src_params.svh
// Constants of the reclocker control block
`ifndef SRC_PARAMS_SVH
`define SRC_PARAMS_SVH
// ************************************
// Register map (byte addresses)
// ************************************
`define SRC_ADDR_W 4
`define SRC_OFF_CTRL 4'h0
`define SRC_OFF_STAT 4'h4
`define SRC_OFF_RATE 4'h8
// ************************************
// Control register fields
// ************************************
`define SRC_CTRL_SW_EN 0
`define SRC_CTRL_RATE_LO 1
`define SRC_CTRL_RATE_HI 2
`define SRC_CTRL_BYPASS 3
`define SRC_CTRL_MUTE_N 4
`define SRC_CTRL_SCO_EN 5
`define SRC_CTRL_W 6
`define SRC_CTRL_RST 6'h10
// ************************************
// Status register fields
// ************************************
`define SRC_STAT_LOCK 0
`define SRC_STAT_RATE 1
`define SRC_STAT_BYP 2
`define SRC_STAT_MUTE 3
`define SRC_STAT_TEST 4
// ************************************
// Pad pull levels
// ************************************
`define SRC_PULL_RATE 2'h0
`define SRC_PULL_BYPASS 1'h0
`define SRC_PULL_SCO_EN 1'h0
`define SRC_PULL_MUTE_N 1'h1
// ************************************
// Timing
// ************************************
`define SRC_CLK_PS 8000
`define SRC_RATE_VALID_PS 37000
`define SRC_RATE_VALID_CYC ((`SRC_RATE_VALID_PS + `SRC_CLK_PS - 1) / `SRC_CLK_PS)
`define SRC_UNLOCK_MAX_NS 1000000
`define SRC_UNLOCK_MAX_CYC ((`SRC_UNLOCK_MAX_NS * 1000) / `SRC_CLK_PS)
`endif

// File: hw/src_pkg.sv
// Types of the reclocker control block
package src_pkg;
  typedef enum logic [1:0] {
    RSEL_AUTO = 2'b00,
    RSEL_SD = 2'b01,
    RSEL_HD = 2'b10,
    RSEL_TEST = 2'b11
  } src_rsel_t;

  typedef enum logic [3:0] {
    RD_NONE = 4'h0, RD_270 = 4'h1, RD_1483 = 4'h2, RD_1485 = 4'h3,
    RD_2967 = 4'h4, RD_2970 = 4'h5, RD_143 = 4'h6, RD_177 = 4'h7,
    RD_360 = 4'h8, RD_540 = 4'h9, RD_HARM = 4'ha, RD_OTHER = 4'hb
  } src_rdet_t;

  typedef enum logic [1:0] {
    OM_MUTE = 2'b00,
    OM_RETIMED = 2'b01,
    OM_BYPASS = 2'b10,
    OM_CLOCK = 2'b11
  } src_omode_t;

  typedef struct packed {
    src_omode_t mode;
    logic leg_p;
    logic leg_n;
  } src_out_t;

  // Declared from the top bit down so that sw_en lands in bit 0 of the control word
  typedef struct packed {
    logic sco_en;
    logic mute_n;
    logic bypass;
    src_rsel_t rate;
    logic sw_en;
  } src_ctrl_t;
endpackage : src_pkg

// File: hw/src_sync2.sv
// Two-flop synchroniser with a reset level
module src_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= RST;
      q <= RST;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : src_sync2

// File: hw/src_reclocker_ctrl.sv
// Reclocker control: rate select, lock, bypass, mute and output multiplexing
//
// Our own choices: the register offsets and the Wishbone slave port.
`include "src_params.svh"

module src_reclocker_ctrl
  import src_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  // Control pins
  input wire logic [1:0] I_RATE_SEL,
  input wire logic I_BYPASS,
  input wire logic I_MUTE_N,
  input wire logic I_SCO_EN,
  // Analog front-end status
  input wire logic I_CARRIER,
  input wire logic I_PLL_LOCK,
  input wire logic [3:0] I_RATE_DET,
  // Output stage control
  output src_out_t O_PRIMARY_DATA_OUT,
  output src_out_t O_SECOND_OUTPUT_MUX,
  // Indicators
  output logic O_PLL_LOCKED_FLAG,
  output logic O_RATE_CLASS_INDICATOR,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [`SRC_ADDR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK
);
  localparam int RV_CYC = `SRC_RATE_VALID_CYC;

  // ************************************
  // Pin and front-end synchronisers
  // ************************************
  logic [1:0] rate_pin;
  logic byp_pin, mute_n_pin, sco_pin;
  logic carrier_s, pll_lock_s;
  logic [3:0] rdet_s;

  src_sync2 #(.W(5), .RST({`SRC_PULL_RATE, `SRC_PULL_BYPASS, `SRC_PULL_MUTE_N, `SRC_PULL_SCO_EN})) u_sync_pins (
    .clk(I_CLK),
    .arst_n(I_ARST_N),
    .d({I_RATE_SEL, I_BYPASS, I_MUTE_N, I_SCO_EN}),
    .q({rate_pin, byp_pin, mute_n_pin, sco_pin})
  );

  src_sync2 #(.W(6), .RST(6'h00)) u_sync_afe (
    .clk(I_CLK),
    .arst_n(I_ARST_N),
    .d({I_CARRIER, I_PLL_LOCK, I_RATE_DET}),
    .q({carrier_s, pll_lock_s, rdet_s})
  );

  // ************************************
  // Register file
  // ************************************
  src_ctrl_t ctrl_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic wb_req;
  logic lock_r, rate_r, byp_act, muted, test_mode;
  src_rdet_t rdet_r;

  assign wb_req = I_WB_CYC && I_WB_STB && !ack_r;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ctrl_r <= `SRC_CTRL_RST;
    end else if (ack_r && I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == `SRC_OFF_CTRL) begin
      ctrl_r <= I_WB_DAT[`SRC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r <= wb_req;
      rdat_r <= 32'h0;
      if (wb_req && !I_WB_WE) begin
        if (I_WB_ADR == `SRC_OFF_CTRL) begin
          rdat_r <= {26'h0, ctrl_r};
        end else if (I_WB_ADR == `SRC_OFF_STAT) begin
          rdat_r[`SRC_STAT_LOCK] <= lock_r;
          rdat_r[`SRC_STAT_RATE] <= rate_r;
          rdat_r[`SRC_STAT_BYP] <= byp_act;
          rdat_r[`SRC_STAT_MUTE] <= muted;
          rdat_r[`SRC_STAT_TEST] <= test_mode;
        end else if (I_WB_ADR == `SRC_OFF_RATE) begin
          rdat_r <= {28'h0, rdet_r};
        end
      end
    end
  end

  assign O_WB_ACK = ack_r;
  assign O_WB_DAT = rdat_r;

  // ************************************
  // Effective controls
  // ************************************
  src_rsel_t rsel;
  logic byp_force, mute_n_eff, sco_en;

  assign rsel = ctrl_r.sw_en ? ctrl_r.rate : src_rsel_t'(rate_pin);
  assign byp_force = ctrl_r.sw_en ? ctrl_r.bypass : byp_pin;
  assign mute_n_eff = ctrl_r.sw_en ? ctrl_r.mute_n : mute_n_pin;
  assign sco_en = ctrl_r.sw_en ? ctrl_r.sco_en : sco_pin;
  assign test_mode = rsel == RSEL_TEST;

  // ************************************
  // Rate detector qualification
  // ************************************
  logic [3:0] rdet_prev_r;
  logic rdet_chg;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdet_prev_r <= 4'h0;
      rdet_r <= RD_NONE;
    end else begin
      rdet_prev_r <= rdet_s;
      if (rdet_s == rdet_prev_r) begin
        rdet_r <= src_rdet_t'(rdet_s);
      end
    end
  end

  assign rdet_chg = rdet_s != rdet_prev_r || src_rdet_t'(rdet_s) != rdet_r;

  // ************************************
  // Lock decision
  // ************************************
  logic is_sd, is_hd, supported, family_ok, lock_nxt;

  assign is_sd = rdet_r == RD_270;
  assign is_hd = rdet_r == RD_1483 || rdet_r == RD_1485 || rdet_r == RD_2967 || rdet_r == RD_2970;
  assign supported = is_sd || is_hd;

  always_comb begin
    case (rsel)
      RSEL_AUTO: family_ok = supported;
      RSEL_SD: family_ok = is_sd;
      RSEL_HD: family_ok = is_hd;
      default: family_ok = 1'b0;
    endcase
  end

  assign lock_nxt = carrier_s && pll_lock_s && family_ok && !rdet_chg;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      lock_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  assign O_PLL_LOCKED_FLAG = lock_r;

  // ************************************
  // Rate class indicator
  // ************************************
  logic lock_d_r;
  logic [2:0] rv_cnt_r;

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      lock_d_r <= 1'b0;
      rv_cnt_r <= 3'h0;
      rate_r <= 1'b0;
    end else begin
      lock_d_r <= lock_r;
      if (lock_r != lock_d_r) begin
        rv_cnt_r <= 3'(RV_CYC - 1);
      end else if (rv_cnt_r != 3'h0) begin
        rv_cnt_r <= rv_cnt_r - 3'h1;
      end
      if (!lock_r) begin
        rate_r <= 1'b0;
      end else if (rv_cnt_r == 3'h1) begin
        rate_r <= is_sd;
      end
    end
  end

  assign O_RATE_CLASS_INDICATOR = rate_r;

  // ************************************
  // Output multiplexing
  // ************************************
  src_out_t pri_nxt, sec_nxt, pri_r, sec_r;

  assign muted = !mute_n_eff;
  assign byp_act = byp_force || !lock_r;

  always_comb begin
    pri_nxt = '{mode: OM_RETIMED, leg_p: 1'b0, leg_n: 1'b0};
    sec_nxt = '{mode: OM_RETIMED, leg_p: 1'b0, leg_n: 1'b0};
    if (muted) begin
      pri_nxt = '{mode: OM_MUTE, leg_p: 1'b1, leg_n: 1'b0};
    end else if (byp_act) begin
      pri_nxt.mode = OM_BYPASS;
    end
    if (muted || (sco_en && byp_act)) begin
      sec_nxt = '{mode: OM_MUTE, leg_p: 1'b1, leg_n: 1'b0};
    end else if (sco_en) begin
      sec_nxt.mode = OM_CLOCK;
    end else if (byp_act) begin
      sec_nxt.mode = OM_BYPASS;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pri_r <= '{mode: OM_MUTE, leg_p: 1'b1, leg_n: 1'b0};
      sec_r <= '{mode: OM_MUTE, leg_p: 1'b1, leg_n: 1'b0};
    end else begin
      pri_r <= pri_nxt;
      sec_r <= sec_nxt;
    end
  end

  assign O_PRIMARY_DATA_OUT = pri_r;
  assign O_SECOND_OUTPUT_MUX = sec_r;

  // ************************************
  // Assertions
  // ************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);

  AST_LOCK_CAUSE: assert property (lock_r |-> $past(carrier_s) && $past(pll_lock_s))
    else $error("Lock flag high without carrier and PLL lock");
  AST_NO_BAD_RATE: assert property (lock_r |-> $past(supported))
    else $error("Locked at an unsupported rate");
  AST_UNSUP_BYPASS: assert property (
    !supported && !muted ##1 !muted |-> O_PRIMARY_DATA_OUT.mode == OM_BYPASS)
    else $error("Unsupported rate not bypassed");
  AST_TEST_NOLOCK: assert property (test_mode |=> !lock_r)
    else $error("Locked in test mode");
  AST_FAMILY: assert property (rsel == RSEL_SD && !is_sd |=> !lock_r)
    else $error("Fixed SD mode locked to other rate");
  AST_MUTE_BOTH: assert property (muted |=> O_PRIMARY_DATA_OUT.mode == OM_MUTE
    && O_SECOND_OUTPUT_MUX.mode == OM_MUTE)
    else $error("Mute did not silence both outputs");
  AST_MUTE_LEGS: assert property (O_SECOND_OUTPUT_MUX.mode == OM_MUTE |->
    O_SECOND_OUTPUT_MUX.leg_p != O_SECOND_OUTPUT_MUX.leg_n)
    else $error("Muted output legs not opposite");
  AST_CLK_BYP_MUTE: assert property (sco_en && byp_force |=> O_SECOND_OUTPUT_MUX.mode == OM_MUTE)
    else $error("Clock output not muted in bypass");
  AST_CLK_SEL: assert property (sco_en && !muted && !byp_act |=> O_SECOND_OUTPUT_MUX.mode == OM_CLOCK)
    else $error("Clock mode not selected");
  AST_FORCE_BYP: assert property (byp_force && !muted |=> O_PRIMARY_DATA_OUT.mode == OM_BYPASS)
    else $error("Forced bypass not applied");
  AST_RETIME: assert property (!byp_force && lock_r && !muted |=> O_PRIMARY_DATA_OUT.mode == OM_RETIMED)
    else $error("Locked data not retimed");
  AST_RATE_LOW: assert property (!lock_r |=> !rate_r)
    else $error("Rate indicator high while unlocked");
  AST_RATE_VALID: assert property ($rose(lock_r) && is_sd ##1 (is_sd && lock_r) [*4] |=> rate_r)
    else $error("Rate indicator not valid after lock");
  AST_UNLOCK_CHG: assert property (rdet_chg |=> !lock_r)
    else $error("Lock kept across rate change");
  // Lock refusal and acceptance, output selection and indicator checks
  AST_HD_FAMILY: assert property (
    rsel == RSEL_HD && !is_hd |=> !lock_r)
    else $error("Fixed HD mode locked to other rate");
  AST_AUTO_FAMILY: assert property (
    rsel == RSEL_AUTO && !supported |=> !lock_r)
    else $error("Auto mode locked to unsupported rate");
  AST_NO_CARRIER: assert property (
    !carrier_s |=> !lock_r)
    else $error("Lock flag high without data present");
  AST_NO_PLL: assert property (
    !pll_lock_s |=> !lock_r)
    else $error("Lock flag high with PLL unlocked");
  AST_HARM_NOLOCK: assert property (
    rdet_r == RD_HARM |=> !lock_r)
    else $error("Locked to a harmonic");
  AST_UNSUP_NOLOCK: assert property (
    rdet_r == RD_143 || rdet_r == RD_177 || rdet_r == RD_360 || rdet_r == RD_540 |=> !lock_r)
    else $error("Locked at a refused rate");
  AST_SD_LOCK: assert property (
    rsel == RSEL_SD && is_sd && carrier_s && pll_lock_s && !rdet_chg |=> lock_r)
    else $error("Fixed SD mode did not lock at its rate");
  AST_AUTO_BYP: assert property (
    !byp_force && !lock_r && !muted |=> O_PRIMARY_DATA_OUT.mode == OM_BYPASS)
    else $error("Unlocked data not bypassed");
  AST_MUTE_PRIO: assert property (
    muted && byp_force |=> O_PRIMARY_DATA_OUT.mode == OM_MUTE && O_SECOND_OUTPUT_MUX.mode == OM_MUTE)
    else $error("Bypass overrode mute");
  AST_SEC_DATA: assert property (
    !sco_en && !muted && !byp_act |=> O_SECOND_OUTPUT_MUX.mode == OM_RETIMED)
    else $error("Second output not retimed data");
  AST_SEC_BYP_DATA: assert property (
    !sco_en && !muted && byp_act |=> O_SECOND_OUTPUT_MUX.mode == OM_BYPASS)
    else $error("Second output not bypassed data");
  AST_CLK_AUTO_MUTE: assert property (
    sco_en && !lock_r |=> O_SECOND_OUTPUT_MUX.mode == OM_MUTE)
    else $error("Clock output not muted in auto bypass");
  AST_PRI_LEGS: assert property (
    O_PRIMARY_DATA_OUT.mode == OM_MUTE |-> O_PRIMARY_DATA_OUT.leg_p != O_PRIMARY_DATA_OUT.leg_n)
    else $error("Muted primary legs not opposite");
  AST_RATE_HD: assert property (
    lock_r && is_hd |=> !rate_r)
    else $error("Rate indicator high at an HD rate");

  COV_LOCK_SD: cover property ($rose(lock_r) ##[1:8] rate_r);
  COV_CLOCK_OUT: cover property (O_SECOND_OUTPUT_MUX.mode == OM_CLOCK);
  COV_AUTO_BYP: cover property (!byp_force && !lock_r && O_PRIMARY_DATA_OUT.mode == OM_BYPASS);
  COV_MUTE: cover property (muted ##1 O_PRIMARY_DATA_OUT.mode == OM_MUTE);
  COV_LOCK_HD: cover property ($rose(lock_r) && is_hd);
endmodule : src_reclocker_ctrl

// File: bench/src_front_model.sv
// Upstream equalizer and PLL front-end model driving the control block
module src_front_model
  import src_pkg::*;
#(
  parameter int FAST_LAG = 2,
  parameter int SLOW_LAG = 9
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Commands from the bench
  input wire logic i_present,
  input wire logic i_pll_ok,
  input wire logic i_slow,
  input wire logic [3:0] i_rate,
  // Front-end status
  output logic o_carrier,
  output logic o_pll_lock,
  output logic [3:0] o_rate_det
);
  int lag_cnt;
  // PLL reports lock only after a settling time, prompt or slow
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lag_cnt <= 0;
      o_pll_lock <= 1'b0;
    end else if (!i_pll_ok) begin
      lag_cnt <= 0;
      o_pll_lock <= 1'b0;
    end else if (lag_cnt < (i_slow ? SLOW_LAG : FAST_LAG)) begin
      lag_cnt <= lag_cnt + 1;
    end else begin
      o_pll_lock <= 1'b1;
    end
  end
  assign o_carrier = i_present;
  // ASI traffic at 270 reports the same rate code as video at 270
  assign o_rate_det = i_present ? i_rate : RD_NONE;
endmodule : src_front_model

// File: bench/test_sdi_reclocker_control.sv
// Self-checking testbench of the reclocker control block
`define CHK(g, e) chk(32'(g), 32'(e))
module test_sdi_reclocker_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0, byp = 1'b0, mn = 1'b1, sco = 1'b0;
  logic pres = 1'b1, pok = 1'b1, slw = 1'b0, tie = 1'b0;
  logic [1:0] rsel = 2'h0;
  logic [3:0] rate = 4'h1, wadr = 4'h0, wsel = 4'h0;
  logic wcyc = 1'b0, wstb = 1'b0, wwe = 1'b0, car, pll, ld, ri, ack;
  logic [3:0] rdet, po, so;
  logic [31:0] wdat = 32'h0, rdat, q, v;
  logic [5:0] ctl = 6'h10;
  int err_total = 0, total_checks = 0, seed = 80142, n, m;
  always #4 clk = ~clk;
  src_front_model u_src_front_model (.i_clk(clk), .i_arst_n(arst_n), .i_present(pres), .i_pll_ok(pok),
    .i_slow(slw), .i_rate(rate), .o_carrier(car), .o_pll_lock(pll), .o_rate_det(rdet));
  src_reclocker_ctrl u_src_reclocker_ctrl (.I_CLK(clk), .I_ARST_N(arst_n), .I_RATE_SEL(rsel), .I_BYPASS(byp),
    .I_MUTE_N(mn), .I_SCO_EN(sco), .I_CARRIER(car), .I_PLL_LOCK(pll), .I_RATE_DET(rdet),
    .O_PRIMARY_DATA_OUT(po), .O_SECOND_OUTPUT_MUX(so), .O_PLL_LOCKED_FLAG(ld), .O_RATE_CLASS_INDICATOR(ri),
    .I_WB_CYC(wcyc), .I_WB_STB(wstb), .I_WB_WE(wwe), .I_WB_ADR(wadr), .I_WB_SEL(wsel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack));
  // Mute input tied to the lock indicator, as a system may wire it
  always @(posedge clk) if (tie) mn <= ld;
  // ************************************
  // Tasks
  // ************************************
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    wcyc <= 1'b1;
    wstb <= 1'b1;
    wwe <= we;
    wadr <= a;
    wdat <= d;
    wsel <= 4'hf;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      conclude();
    end
    r = rdat;
    wcyc <= 1'b0;
    wstb <= 1'b0;
    @(posedge clk);
  endtask : wb
  // Behavioural model compared with every output once the pins have settled
  task automatic check_all;
    int es, eb, em, ec, rd, lk, bp, p, s, rc;
    repeat (24) @(posedge clk);
    es = ctl[0] ? int'(ctl[2:1]) : int'(rsel);
    eb = ctl[0] ? ctl[3] : byp;
    ec = ctl[0] ? ctl[5] : sco;
    rd = pres ? int'(rate) : 0;
    lk = pres && pok && (es == 0 ? rd >= 1 && rd <= 5 : es == 1 ? rd == 1 : es == 2 ? rd >= 2 && rd <= 5 : 0);
    em = tie ? lk : ctl[0] ? ctl[4] : mn;
    bp = eb || !lk;
    p = !em ? 2 : bp ? 8 : 4;
    s = !em ? 2 : !ec ? p : bp ? 2 : 12;
    rc = lk && rd == 1;
    `CHK(po, p);
    `CHK(so, s);
    `CHK(ld, lk);
    `CHK(ri, rc);
    wb(1'b0, 4'h4, 32'h0, q);
    `CHK(q, lk | rc << 1 | bp << 2 | !em << 3 | (es == 3) << 4);
    wb(1'b0, 4'h8, 32'h0, q);
    `CHK(q, rd);
  endtask : check_all
  // ************************************
  // Sequence
  // ************************************
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    `CHK({po, so}, 8'h22);
    arst_n <= 1'b1;
    check_all();
    wb(1'b0, 4'h0, 32'h0, q);
    `CHK(q, 32'h10);
    wb(1'b1, 4'h4, 32'hff, q);
    wb(1'b0, 4'hc, 32'h0, q);
    `CHK(q, 32'h0);
    wb(1'b1, 4'h0, 32'h2f, q);
    ctl = 6'h2f;
    check_all();
    wb(1'b1, 4'h0, 32'h13, q);
    ctl = 6'h13;
    wb(1'b0, 4'h0, 32'h0, q);
    `CHK(q, 32'h13);
    check_all();
    wb(1'b1, 4'h0, 32'h10, q);
    ctl = 6'h10;
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 12; r++) begin
        rsel <= 2'(s);
        rate <= 4'(r);
        sco <= r[0];
        check_all();
      end
    end
    $display("test rate sweep done");
    for (int i = 0; i < 40; i++) begin
      v = $random(seed);
      {rsel, byp, sco, slw} <= v[4:0];
      mn <= v[5] | v[6];
      pres <= v[7] | v[8];
      pok <= v[9] | v[10];
      rate <= 4'(v[14:11] % 12);
      check_all();
    end
    $display("test random done");
    {rsel, byp, mn, sco, pok, slw, pres} <= 8'h4e;
    rate <= 4'h1;
    check_all();
    pres <= 1'b1;
    n = 0;
    m = 0;
    while (ld !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK(n < 40, 1);
    while (ri !== 1'b1 && m < 20) begin
      @(posedge clk);
      m++;
    end
    `CHK(m, 5);
    rate <= 4'h2;
    n = 0;
    @(posedge clk);
    while (ld !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK(n <= 8, 1);
    repeat (5) @(posedge clk);
    `CHK(ri, 0);
    check_all();
    $display("test lock timing done");
    tie <= 1'b1;
    for (int r = 0; r < 3; r++) begin
      rate <= 4'(r);
      check_all();
    end
    $display("test tied mute done");
    conclude();
  end
endmodule : test_sdi_reclocker_control
